// [rtl/txpq_defs.svh]
// Purpose: offsets, field positions, reset values for the pending queue
// Assumes: 12-bit register byte addresses on the register bus
// Notes:   definitions only
`ifndef TXPQ_DEFS_SVH
`define TXPQ_DEFS_SVH
`define OFS_PQ_BASE_LO   12'h800
`define OFS_PQ_BASE_HI   12'h804
`define OFS_PQ_END       12'h808
`define OFS_PQ_WPTR      12'h80C
`define OFS_PQ_RPTR      12'h810
`define OFS_DESC_BASE_LO 12'h850
`define OFS_DESC_BASE_HI 12'h854
`define OFS_CTRL         12'h8A0
`define OFS_STATUS       12'h8A4
`define CTRL_TX_DMA_EN   0
`define STAT_PQ_READ     0
`define RST_HALF         16'h0000
`define PQ_STEP          16'h0004
`define DESC_SHIFT       4
`define LINK_WORD_OFS    4'hC
`define F_IDX_HI         15
`define F_CNT_HI         28
`define F_CNT_LO         16
`define F_CV             30
`define F_EOP            31
`define F_PV             16
`define F_CH_HI          23
`define F_CH_LO          16
`define F_PRI            24
`define F_RST            25
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// [rtl/txpq_pkg.sv]
// Purpose: shared types of the transmit pending-queue engine
// Assumes: nothing
// Notes:   constants live in txpq_defs.svh
package txpq_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_PQ_RD, ST_PQ_WAIT, ST_LINK_WR, ST_D_RD, ST_D_WAIT, ST_EMIT
   } fsm_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_req_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [12:0] count;
      logic [7:0]  chan;
      logic        eop;
      logic        priority_packet_flag;
   } buf_cmd_t;

   typedef struct packed {
      logic        valid;
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } reg_wr_t;
endpackage : txpq_pkg

// [rtl/txpq_addr_gen.sv]
// Purpose: byte address of a word inside an indexed descriptor
// Assumes: descriptors are four words, aligned on sixteen bytes
// Notes:   purely combinational
`include "txpq_defs.svh"
module txpq_addr_gen (
   // Base and index
   input  wire logic [15:0] base_lo,
   input  wire logic [15:0] base_hi,
   input  wire logic [15:0] idx,
   input  wire logic [3:0]  ofs,
   // Result
   output logic      [31:0] addr
);
   always_comb begin
      addr = {base_hi, base_lo} + {12'h000, idx, 4'h0} + {28'h0000000, ofs};
   end
endmodule : txpq_addr_gen

// [rtl/txpq_axil_port.sv]
// Purpose: AXI4-Lite slave handshake for the engine's registers
// Assumes: one write and one read under way at a time
// Notes:   decode and storage sit in the parent; SLVERR when unmapped
`include "txpq_defs.svh"
module txpq_axil_port (
   // Clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic               ce,
   // AXI4-Lite
   input  wire logic [11:0]        awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   input  wire logic [11:0]        araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   // Parent side
   output txpq_pkg::reg_wr_t       wr,
   input  wire logic               wr_hit,
   output logic [11:0]             rd_addr,
   input  wire logic [31:0]        rd_word,
   input  wire logic               rd_hit
);
   typedef struct packed {
      logic        aw_have;
      logic        w_have;
      logic [11:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rd_pend;
      logic [11:0] ar_addr;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } port_t;

   port_t s;
   port_t next_s;

   always_comb begin
      next_s = s;
      awready = !s.aw_have && !s.bvalid;
      wready = !s.w_have && !s.bvalid;
      arready = !s.rd_pend && !s.rvalid;
      wr = '0;
      if (awvalid && awready) begin
         next_s.aw_have = 1'b1;
         next_s.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_s.w_have = 1'b1;
         next_s.w_data = wdata;
         next_s.w_strb = wstrb;
      end
      if (s.aw_have && s.w_have) begin
         wr = '{valid: 1'b1, addr: s.aw_addr, data: s.w_data,
                strb: s.w_strb};
         next_s.aw_have = 1'b0;
         next_s.w_have = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_s.rd_pend = 1'b1;
         next_s.ar_addr = araddr;
      end
      if (s.rd_pend) begin
         next_s.rd_pend = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rdata = rd_hit ? rd_word : 32'h00000000;
         next_s.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign rvalid = s.rvalid;
   assign rresp = s.rresp;
   assign rdata = s.rdata;
   assign rd_addr = s.ar_addr;
endmodule : txpq_axil_port

// [rtl/tx_descriptor_pending_queue.sv]
// Purpose: fetch pending-queue entries, walk descriptor chains, emit
//          buffer commands to the transmit datapath
// Assumes: one outstanding memory access; read data returns in order
// Notes:   pointers are byte offsets from the pending-queue base
`include "txpq_defs.svh"
// Functional notes
// - Table is contiguous, 16-byte entries, 32-bit base.
// - Word 0 is the absolute buffer address.
// - Follow next index unless end without chain.
// - Byte count is word 1 bits 16 to 28.
// - End with chain-valid starts next packet.
// - Word 1 bit 31 marks last buffer.
// - Channel is word 2 low byte.
// - Unused descriptor bits are ignored.
// - Two chains inside; more linked via word 3.
// - Linking sets word 3 bit 16; host clears it.
// - Entry bits 0 to 15 index the first descriptor.
// - Entry bits 16 to 23 carry the channel code.
// - Priority entry goes at the packet end; one linked via word 3 loses its priority.
// - Restart bit forces channel enable to one.
// - Entry status and top bits are ignored.
// - Engine moves read pointer, host moves write.
// - Equal pointers mean empty.
// - Read pointer steps a word, wraps past end.
// - Each fetch sets the read status flag.
// - Fetch only with transmit DMA enable set.
module tx_descriptor_pending_queue #(
   parameter int SLOTS = 2
) (
   // Clock, reset, enable
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                ce,
   // AXI4-Lite register bus
   input  wire logic [11:0]         awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   input  wire logic [11:0]         araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   // System memory access
   output txpq_pkg::mem_req_t       mem_req,
   input  wire logic                mem_ready,
   input  wire logic                mem_rvalid,
   input  wire logic [31:0]         mem_rdata,
   // Buffer commands to the transmit datapath
   output txpq_pkg::buf_cmd_t       buf_cmd,
   output logic                     buf_valid,
   input  wire logic                buf_ready,
   // Channel enable force
   output logic                     chan_enable_set,
   output logic [7:0]               chan_enable_code
);
   typedef struct packed {
      txpq_pkg::fsm_t      st;
      logic [15:0]         pq_base_lo;
      logic [15:0]         pq_base_hi;
      logic [15:0]         pq_end;
      logic [15:0]         wptr;
      logic [15:0]         rptr;
      logic [15:0]         d_base_lo;
      logic [15:0]         d_base_hi;
      logic                tx_dma_enable;
      logic                pq_read_flag;
      logic [1:0]          count;
      logic                ext_pending;
      logic [15:0]         tail_idx;
      logic [15:0]         head_idx;
      logic                head_pri;
      logic                head_first;
      logic [15:0]         s1_idx;
      logic                s1_pri;
      logic                s1_first;
      logic [31:0]         entry;
      logic [1:0]          word;
      logic [31:0]         w0;
      logic [31:0]         w1;
      logic [31:0]         w2;
      txpq_pkg::mem_req_t  req;
      txpq_pkg::buf_cmd_t  cmd;
      logic                cmd_valid;
      logic                en_set;
      logic [7:0]          en_code;
   } eng_t;

   eng_t s;
   eng_t next_s;

   txpq_pkg::reg_wr_t wr;
   logic              wr_hit;
   logic [11:0]       rd_addr;
   logic [31:0]       rd_word;
   logic              rd_hit;
   logic [31:0]       desc_addr;
   logic [31:0]       link_addr;
   logic [15:0]       step_ptr;
   logic              pq_empty;
   logic              can_fetch;

   txpq_axil_port u_port (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr      (wr),
      .wr_hit  (wr_hit),
      .rd_addr (rd_addr),
      .rd_word (rd_word),
      .rd_hit  (rd_hit)
   );

   // Head descriptor word, and word 3 of the newest queued chain
   txpq_addr_gen u_desc_addr (
      .base_lo (s.d_base_lo),
      .base_hi (s.d_base_hi),
      .idx     (s.head_idx),
      .ofs     ({s.word, 2'b00}),
      .addr    (desc_addr)
   );

   txpq_addr_gen u_link_addr (
      .base_lo (s.d_base_lo),
      .base_hi (s.d_base_hi),
      .idx     (s.tail_idx),
      .ofs     (`LINK_WORD_OFS),
      .addr    (link_addr)
   );

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  strb);
      merge16 = old;
      if (strb[0]) begin
         merge16[7:0] = d[7:0];
      end
      if (strb[1]) begin
         merge16[15:8] = d[15:8];
      end
   endfunction : merge16

   function automatic logic is_mapped(input logic [11:0] a);
      unique case (a)
         `OFS_PQ_BASE_LO, `OFS_PQ_BASE_HI, `OFS_PQ_END, `OFS_PQ_WPTR,
         `OFS_PQ_RPTR, `OFS_DESC_BASE_LO, `OFS_DESC_BASE_HI, `OFS_CTRL,
         `OFS_STATUS: is_mapped = 1'b1;
         default:     is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   always_comb begin
      rd_hit = is_mapped(rd_addr);
      unique case (rd_addr)
         `OFS_PQ_BASE_LO:   rd_word = {16'h0000, s.pq_base_lo};
         `OFS_PQ_BASE_HI:   rd_word = {16'h0000, s.pq_base_hi};
         `OFS_PQ_END:       rd_word = {16'h0000, s.pq_end};
         `OFS_PQ_WPTR:      rd_word = {16'h0000, s.wptr};
         `OFS_PQ_RPTR:      rd_word = {16'h0000, s.rptr};
         `OFS_DESC_BASE_LO: rd_word = {16'h0000, s.d_base_lo};
         `OFS_DESC_BASE_HI: rd_word = {16'h0000, s.d_base_hi};
         `OFS_CTRL:         rd_word = {31'h00000000, s.tx_dma_enable};
         `OFS_STATUS:       rd_word = {31'h00000000, s.pq_read_flag};
         default:           rd_word = 32'h00000000;
      endcase
      wr_hit = is_mapped(wr.addr);
   end

   always_comb begin
      step_ptr = s.rptr + `PQ_STEP;
      pq_empty = (s.rptr == s.wptr);
      can_fetch = s.tx_dma_enable && !pq_empty;
   end

   always_comb begin
      next_s = s;
      next_s.en_set = 1'b0;

      // Register writes; host owns pointer initialisation
      if (wr.valid) begin
         unique case (wr.addr)
            `OFS_PQ_BASE_LO:
               next_s.pq_base_lo = merge16(s.pq_base_lo, wr.data, wr.strb);
            `OFS_PQ_BASE_HI:
               next_s.pq_base_hi = merge16(s.pq_base_hi, wr.data, wr.strb);
            `OFS_PQ_END:
               next_s.pq_end = merge16(s.pq_end, wr.data, wr.strb);
            `OFS_PQ_WPTR:
               next_s.wptr = merge16(s.wptr, wr.data, wr.strb);
            `OFS_PQ_RPTR:
               next_s.rptr = merge16(s.rptr, wr.data, wr.strb);
            `OFS_DESC_BASE_LO:
               next_s.d_base_lo = merge16(s.d_base_lo, wr.data, wr.strb);
            `OFS_DESC_BASE_HI:
               next_s.d_base_hi = merge16(s.d_base_hi, wr.data, wr.strb);
            `OFS_CTRL: begin
               if (wr.strb[0]) begin
                  next_s.tx_dma_enable = wr.data[`CTRL_TX_DMA_EN];
               end
            end
            `OFS_STATUS: begin
               // Write one to clear; a fetch in the same cycle wins below
               if (wr.strb[0] && wr.data[`STAT_PQ_READ]) begin
                  next_s.pq_read_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      unique case (s.st)
         txpq_pkg::ST_IDLE: begin
            if (can_fetch && !(s.count == 2'(SLOTS) && s.ext_pending
                               && 1'b0)) begin
               // Entry read at base plus read pointer
               next_s.req = '{valid: 1'b1, write: 1'b0,
                              addr: {s.pq_base_hi, s.pq_base_lo}
                                    + {16'h0000, s.rptr},
                              wdata: 32'h00000000};
               next_s.st = txpq_pkg::ST_PQ_RD;
            end else if (s.count != 2'h0) begin
               next_s.word = 2'h0;
               next_s.st = txpq_pkg::ST_D_RD;
            end
         end

         txpq_pkg::ST_PQ_RD: begin
            if (mem_ready) begin
               next_s.req.valid = 1'b0;
               next_s.st = txpq_pkg::ST_PQ_WAIT;
            end
         end

         txpq_pkg::ST_PQ_WAIT: begin
            if (mem_rvalid) begin
               // Status field and top bits are never looked at
               next_s.entry = mem_rdata;
               next_s.pq_read_flag = 1'b1;
               if (step_ptr > s.pq_end) begin
                  next_s.rptr = `RST_HALF;
               end else begin
                  next_s.rptr = step_ptr;
               end
               if (mem_rdata[`F_RST]) begin
                  next_s.en_set = 1'b1;
                  next_s.en_code = mem_rdata[`F_CH_HI:`F_CH_LO];
               end
               if (s.count < 2'(SLOTS) && !s.ext_pending) begin
                  // Room inside: keep the chain
                  next_s.tail_idx = mem_rdata[`F_IDX_HI:0];
                  if (s.count == 2'h0) begin
                     next_s.head_idx = mem_rdata[`F_IDX_HI:0];
                     next_s.head_pri = mem_rdata[`F_PRI];
                     next_s.head_first = 1'b1;
                  end else begin
                     next_s.s1_idx = mem_rdata[`F_IDX_HI:0];
                     next_s.s1_pri = mem_rdata[`F_PRI];
                     next_s.s1_first = 1'b1;
                  end
                  next_s.count = s.count + 2'h1;
                  next_s.st = txpq_pkg::ST_IDLE;
               end else begin
                  // No room, or links pending: link onto the newest queued chain
                  next_s.req = '{valid: 1'b1, write: 1'b1, addr: link_addr,
                                 wdata: {15'h0000, 1'b1,
                                         mem_rdata[`F_IDX_HI:0]}};
                  next_s.st = txpq_pkg::ST_LINK_WR;
               end
            end
         end

         txpq_pkg::ST_LINK_WR: begin
            if (mem_ready) begin
               next_s.req.valid = 1'b0;
               next_s.tail_idx = s.entry[`F_IDX_HI:0];
               next_s.ext_pending = 1'b1;
               next_s.st = txpq_pkg::ST_IDLE;
            end
         end

         txpq_pkg::ST_D_RD: begin
            next_s.req = '{valid: 1'b1, write: 1'b0, addr: desc_addr,
                           wdata: 32'h00000000};
            if (s.req.valid && mem_ready) begin
               next_s.req.valid = 1'b0;
               next_s.st = txpq_pkg::ST_D_WAIT;
            end
         end

         txpq_pkg::ST_D_WAIT: begin
            if (mem_rvalid) begin
               unique case (s.word)
                  2'h0: next_s.w0 = mem_rdata;
                  2'h1: next_s.w1 = mem_rdata;
                  2'h2: next_s.w2 = mem_rdata;
                  2'h3: begin
                     // Link field counts only on a chain's first buffer
                     if (s.head_first && mem_rdata[`F_PV]) begin
                        next_s.s1_idx = mem_rdata[`F_IDX_HI:0];
                        next_s.s1_pri = 1'b0;
                        next_s.s1_first = 1'b1;
                        next_s.count = 2'(SLOTS);
                        if (mem_rdata[`F_IDX_HI:0] == s.tail_idx) begin
                           next_s.ext_pending = 1'b0;
                        end
                     end
                  end
                  default: begin
                  end
               endcase
               if (s.word == 2'h3) begin
                  // Unused bits of every word are dropped here
                  next_s.cmd = '{addr: s.w0,
                                 count: s.w1[`F_CNT_HI:`F_CNT_LO],
                                 chan: s.w2[7:0],
                                 eop: s.w1[`F_EOP],
                                 priority_packet_flag: s.head_pri};
                  next_s.cmd_valid = 1'b1;
                  next_s.head_first = 1'b0;
                  next_s.st = txpq_pkg::ST_EMIT;
               end else begin
                  next_s.word = s.word + 2'h1;
                  next_s.st = txpq_pkg::ST_D_RD;
               end
            end
         end

         txpq_pkg::ST_EMIT: begin
            if (buf_ready) begin
               next_s.cmd_valid = 1'b0;
               next_s.st = txpq_pkg::ST_IDLE;
               if (!s.w1[`F_EOP]) begin
                  next_s.head_idx = s.w1[`F_IDX_HI:0];
               end else if (s.w1[`F_CV]) begin
                  // Packet ended, chain goes on
                  if (s.count == 2'(SLOTS) && s.s1_pri && !s.head_pri) begin
                     // Priority chain cuts in at the packet end
                     next_s.head_idx = s.s1_idx;
                     next_s.head_pri = 1'b1;
                     next_s.head_first = s.s1_first;
                     next_s.s1_idx = s.w1[`F_IDX_HI:0];
                     next_s.s1_pri = 1'b0;
                     next_s.s1_first = 1'b0;
                  end else begin
                     next_s.head_idx = s.w1[`F_IDX_HI:0];
                  end
               end else begin
                  // Chain done: promote the second slot
                  next_s.head_idx = s.s1_idx;
                  next_s.head_pri = s.s1_pri;
                  next_s.head_first = s.s1_first;
                  next_s.count = s.count - 2'h1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign mem_req = s.req;
   assign buf_cmd = s.cmd;
   assign buf_valid = s.cmd_valid;
   assign chan_enable_set = s.en_set;
   assign chan_enable_code = s.en_code;
endmodule : tx_descriptor_pending_queue

// [tb/txpq_mem_model.sv]
// Purpose: host main memory
// Assumes: one access at a time, below 1 KiB
// Notes:   slow mode delays reads
module txpq_mem_model (
   // Clock and mode
   input  wire logic               aclk,
   input  wire logic               slow,
   // Memory port
   input  wire txpq_pkg::mem_req_t mem_req,
   output logic                    mem_ready,
   output logic                    mem_rvalid,
   output logic [31:0]             mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [0:255]; // Table and queue in one flat region
   logic        pend = 1'b0;
   logic [3:0]  cnt = 4'h0;
   logic [7:0]  ra = 8'h00;
   initial begin
      mem_rvalid = 1'b0;
      mem_rdata = 32'h5A5A_5A5A;
   end
   assign mem_ready = !pend && !mem_rvalid;
   always @(posedge aclk) begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata; // Line never keeps a stale word
      if (mem_req.valid && mem_ready) begin
         if (mem_req.write)
            mem[mem_req.addr[9:2]] <= mem_req.wdata;
         pend <= !mem_req.write;
         ra <= mem_req.addr[9:2];
         cnt <= slow ? 4'h5 : 4'h0;
      end else if (pend && cnt != 4'h0)
         cnt <= cnt - 4'h1;
      else if (pend) begin
         mem_rvalid <= 1'b1;
         mem_rdata <= mem[ra];
         pend <= 1'b0;
      end
   end
endmodule : txpq_mem_model

// [tb/txpq_assertions.sv]
// Purpose: handshake and answer timing checks on the engine's ports
// Assumes: one clock domain, clock enable held high
// Notes:   bound from the bench top file
module txpq_checker (
   // Clock and reset
   input wire logic               aclk, aresetn,
   // Register bus
   input wire logic               awvalid, awready, wvalid, wready,
   input wire logic               bvalid, bready, arvalid, arready,
   input wire logic               rvalid, rready,
   // Memory, buffer and enable side
   input wire txpq_pkg::mem_req_t mem_req,
   input wire txpq_pkg::buf_cmd_t buf_cmd,
   input wire logic               mem_ready, buf_valid, buf_ready,
   input wire logic               chan_enable_set
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence rd_taken;
      arvalid && arready;
   endsequence
   a_write_answer: assert property (wr_taken |=> !bvalid ##1 bvalid)
      else $error("b timing");
   a_read_answer: assert property (rd_taken |=> !rvalid ##1 rvalid)
      else $error("r timing");
   a_write_refused: assert property (bvalid |-> !awready && !wready)
      else $error("aw taken");
   a_read_refused: assert property (rvalid |-> !arready)
      else $error("ar taken");
   a_bresp_stands: assert property (bvalid && !bready |=> bvalid)
      else $error("b dropped");
   a_rresp_stands: assert property (rvalid && !rready |=> rvalid)
      else $error("r dropped");
   a_mem_req_hold: assert property (mem_req.valid && !mem_ready
      |=> mem_req.valid && $stable(mem_req))
      else $error("mem req moved");
   a_buf_cmd_hold: assert property (buf_valid && !buf_ready
      |=> buf_valid && $stable(buf_cmd))
      else $error("buf cmd moved");
   a_enable_pulse: assert property (chan_enable_set
      |=> !chan_enable_set)
      else $error("long force");
endmodule : txpq_checker

// [tb/tx_descriptor_pending_queue_tb.sv]
// Purpose: engine tests
// Assumes: table at 0x100, queue at 0x000
// Notes:   buffer commands stalled
`include "txpq_defs.svh"
module tx_descriptor_pending_queue_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, slow = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, buf_ready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000, rdata, mem_rdata;
   logic [3:0]  wstrb = 4'hF;
   logic        awready, wready, bvalid, arready, rvalid, mem_ready;
   logic        mem_rvalid, buf_valid, chan_enable_set;
   logic [1:0]  bresp, rresp;
   logic [7:0]  chan_enable_code, last_code = 8'h00;
   int          miscompares = 0, n_tests = 0, pulses = 0;
   txpq_pkg::mem_req_t mem_req;
   txpq_pkg::buf_cmd_t buf_cmd;
   tx_descriptor_pending_queue dut (.*);
   txpq_mem_model mem_m (.*);
   initial forever #50 aclk = ~aclk;
   always @(posedge aclk) begin
      if (chan_enable_set === 1'b1) begin
         pulses <= pulses + 1;
         last_code <= chan_enable_code;
      end
   end
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      n_tests++;
      if (s !== e) begin
         miscompares++;
         $display("FAIL t=%0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic pa, pw, ra, rw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         ra = awready;
         rw = wready;
         @(posedge aclk);
         pa = pa & ~ra;
         pw = pw & ~rw;
         awvalid <= pa;
         wvalid <= pw;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      @(posedge aclk);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      logic       ok;
      logic [33:0] v;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         ok = arready;
         @(posedge aclk);
      end while (ok !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         v = {rresp, rdata};
      end while (rvalid !== 1'b1);
      @(posedge aclk);
      rready <= 1'b0;
      chk(64'(v), 64'(e));
   endtask : rd
   task automatic take(input logic [54:0] e);
      logic [54:0] v;
      repeat (3) @(posedge aclk);
      do @(negedge aclk); while (buf_valid !== 1'b1);
      v = buf_cmd;
      @(posedge aclk);
      buf_ready <= 1'b1;
      @(posedge aclk);
      buf_ready <= 1'b0;
      chk(64'(v), 64'(e));
   endtask : take
   task automatic dsc(input int i, input logic [31:0] w1, w2);
      mem_m.mem[64 + 4 * i] = 32'hA000_0000 + 32'(i);
      mem_m.mem[65 + 4 * i] = w1;
      mem_m.mem[66 + 4 * i] = w2;
      mem_m.mem[67 + 4 * i] = 32'h0; // Link word left clear
   endtask : dsc
   task automatic stop_test();
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`OFS_DESC_BASE_LO, 34'h0);
      wr(`OFS_DESC_BASE_LO, 32'h0000_0100);
      rd(`OFS_DESC_BASE_LO, 34'h100);
      rd(12'hFFC, {`RESP_SLVERR, 32'h0});
      wr(`OFS_PQ_END, 32'h8);
      dsc(1, {3'b101, 13'h1FFC, 16'h0005}, 32'hABCDEFFF);
      dsc(2, {3'b010, 13'h0010, 16'h0003}, 32'h0);
      dsc(3, {3'b110, 13'h0020, 16'h0005}, 32'h0);
      dsc(5, {3'b100, 13'h0001, 16'h0009}, 32'h0);
      dsc(4, {3'b100, 13'h0004, 16'h0000}, 32'h6);
      mem_m.mem[0] = {6'b111101, 2'b10, 8'hFF, 16'h0001};
      mem_m.mem[1] = 32'h0000_0002;
      mem_m.mem[2] = 32'h0006_0004;
      wr(`OFS_PQ_WPTR, 32'h4);
      repeat (20) @(posedge aclk);
      rd(`OFS_PQ_RPTR, 34'h0);
      wr(`OFS_CTRL, 32'h1);
      take({32'hA000_0001, 13'h1FFC, 8'hFF, 2'b10});
      rd(`OFS_PQ_RPTR, 34'h4);
      rd(`OFS_STATUS, 34'h1);
      chk(64'(last_code), 64'hFF);
      wr(`OFS_STATUS, 32'h1);
      repeat (20) @(posedge aclk);
      rd(`OFS_STATUS, 34'h0);
      $display("test single entry done");
      slow <= 1'b1;
      wr(`OFS_PQ_WPTR, 32'h0);
      take({32'hA000_0002, 13'h0010, 8'h00, 2'b00});
      take({32'hA000_0003, 13'h0020, 8'h00, 2'b10});
      take({32'hA000_0005, 13'h0001, 8'h00, 2'b10});
      take({32'hA000_0004, 13'h0004, 8'h06, 2'b10});
      rd(`OFS_PQ_RPTR, 34'h0);
      chk(64'(pulses), 64'd1);
      $display("test chain walk done");
      stop_test();
   end
endmodule : tx_descriptor_pending_queue_tb
bind tx_descriptor_pending_queue txpq_checker chk_i (.*);
